/* File: core/dac_cmd_params.svh */
`ifndef DAC_CMD_PARAMS_SVH
`define DAC_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define WORD_W      16
`define DATA_W      8
`define NCH         8
`define ADDR_W      3
`define CTRL_W      3
`define CNT_W       8
`define DATA_MSB    7
`define DATA_LSB    0
`define CTRL_MSB    10
`define CTRL_LSB    8
`define ADDR_MSB    13
`define ADDR_LSB    11
`define MODE_BIT    13

// ----------------------------------------------------------------
// control codes
// ----------------------------------------------------------------
`define CMD_PASS    3'h0
`define CMD_CLEAR   3'h1
`define CMD_SHDN    3'h2
`define CMD_PHASE   3'h3
`define CMD_ALL     3'h4
`define CMD_LD_IN   3'h5
`define CMD_LD_BOTH 3'h6
`define CMD_UPDATE  3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CODE_ZERO   8'h00
`define BUF_ALL_ON  8'hFF
`define CNT_ZERO    8'h00
`define WORD_ZERO   16'h0000

`endif

/* File: core/dac_cmd_pkg.sv */
package dac_cmd_pkg;
`include "dac_cmd_params.svh"

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_EXEC} seq_state_t;

    typedef logic [`NCH-1:0][`DATA_W-1:0] bank_t;

    typedef struct packed {
        seq_state_t               st;
        logic [`WORD_W-1:0]       word;
        logic [`CNT_W-1:0]        base_cnt;
        bank_t                    inp;
        bank_t                    dac;
        logic                     shutdown;
        logic [`NCH-1:0]          buf_en;
        logic                     mode;
        logic                     cs_prev;
    } core_state_t;

    typedef struct packed {
        logic [`WORD_W-1:0]       sr;
        logic [`CNT_W-1:0]        cnt;
        logic                     pos_out;
        logic                     rst_s1;
        logic                     rst_s2;
        logic                     mode_s1;
        logic                     mode_s2;
    } link_state_t;

    // ------------------------------------------------------------
    // field decoding
    // ------------------------------------------------------------
    function automatic logic [`CTRL_W-1:0] ctrl_of(
        input logic [`WORD_W-1:0] w);
        return w[`CTRL_MSB:`CTRL_LSB];
    endfunction : ctrl_of

    function automatic logic [`ADDR_W-1:0] addr_of(
        input logic [`WORD_W-1:0] w);
        return w[`ADDR_MSB:`ADDR_LSB];
    endfunction : addr_of

    function automatic logic [`DATA_W-1:0] data_of(
        input logic [`WORD_W-1:0] w);
        return w[`DATA_MSB:`DATA_LSB];
    endfunction : data_of

    // at least a whole word clocked in since the last frame end
    function automatic logic full_word(input logic [`CNT_W-1:0] now,
                                       input logic [`CNT_W-1:0] base);
        logic [`CNT_W-1:0] diff;
        diff = now - base;
        return diff >= `CNT_W'(`WORD_W);
    endfunction : full_word

endpackage : dac_cmd_pkg

/* File: core/in_sync3.sv */
`timescale 1ns/1ps
module in_sync3 #(
    parameter int          W       = 2,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         clock,   // system clock
    input  wire logic         rst,     // sync reset, high
    input  wire logic [W-1:0] din,     // asynchronous pins
    output logic      [W-1:0] dout     // filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // three stages; a level counts when stage two and three agree
    always_comb begin
        d      = q;
        d.s1   = din;
        d.s2   = q.s1;
        d.s3   = q.s2;
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s2[i];
            end
        end
        if (rst) begin
            d = {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign dout = q.filt;
endmodule : in_sync3

/* File: core/serial_link_shifter.sv */
`timescale 1ns/1ps
module serial_link_shifter
    import dac_cmd_pkg::*;
(
    input  wire logic               sclk,     // serial clock
    input  wire logic               rst,      // system reset, high
    input  wire logic               cs_n,     // frame select, low
    input  wire logic               sdi,      // serial data in
    input  wire logic               mode_sel, // 1: out on rising
    output logic                    sdo,      // serial data out
    output logic [`WORD_W-1:0]      word,     // shift register
    output logic [`CNT_W-1:0]       bit_cnt   // bits seen, wraps
);
    link_state_t q;
    link_state_t d;
    logic        neg_out_q;

    // shift msb first on rising edges while selected
    always_comb begin
        d         = q;
        d.rst_s1  = rst;
        d.rst_s2  = q.rst_s1;
        d.mode_s1 = mode_sel;
        d.mode_s2 = q.mode_s1;
        if (q.rst_s2) begin
            d.sr      = `WORD_ZERO;
            d.cnt     = `CNT_ZERO;
            d.pos_out = 1'b0;
        end else if (!cs_n) begin
            d.sr      = {q.sr[`WORD_W-2:0], sdi};
            d.cnt     = q.cnt + `CNT_W'(1);
            d.pos_out = q.sr[`WORD_W-1];
        end
    end

    always_ff @(posedge sclk) begin
        q <= d;
    end

    // half-cycle later copy for falling-edge phase
    always_ff @(negedge sclk) begin
        neg_out_q <= q.pos_out;
    end

    // pin is always driven; both copies hold while deselected
    assign sdo     = q.mode_s2 ? q.pos_out : neg_out_q;
    assign word    = q.sr;
    assign bit_cnt = q.cnt;

    // reset clears the copy from unknown, so it is not held then
    a_dout_hold : assert property (@(posedge sclk)
        disable iff (rst)
        cs_n |=> $stable(q.pos_out))
        else $error("serial out moved while deselected");
endmodule : serial_link_shifter

/* File: core/octal_dac_serial_command_decoder.sv */
// Notes on behaviour
// - pass-through code only shifts; no input or output register changes.
// - clear code zeroes every input and output register.
// - clear also ends shutdown.
// - shutdown code powers down; buffers with zero data bits disabled.
// - shutdown ends only on reset, clear, load-all or load-both.
// - phase code with top address bit 0 selects falling edge, updates all.
// - phase code with top address bit 1 selects rising edge, updates all.
// - selected phase is held until reset or another phase command.
// - load-all writes data into all eight outputs and ends shutdown.
// - load-input writes addressed input register only at frame end.
// - load-both writes addressed input and output, ends shutdown.
// - software update copies every input register to its output.
// - while update pin is low, outputs follow input registers.
// - serial out lags input by 16.5 or 16 clock cycles per phase.
// - serial out always driven and frozen while deselected.
// - after reset the phase is falling-edge mode 0.
// - msb first, one bit per rising serial clock while selected.
// - word is two ignored, three address, three control, eight data bits.
// - reset clears serial interface and every code register to zero; buffers all on.
`timescale 1ns/1ps
module octal_dac_serial_command_decoder
    import dac_cmd_pkg::*;
(
    input  wire logic                      clock,       // system clock
    input  wire logic                      rst,         // sync, high
    input  wire logic                      sclk,        // link clock
    input  wire logic                      cs_n,        // select, low
    input  wire logic                      sdi,         // serial in
    input  wire logic                      hw_update_n, // update pin
    output logic                           sdo,         // chain out
    output logic [`NCH*`DATA_W-1:0]        dac_code,    // output codes
    output logic [`NCH-1:0]                buf_en,      // buffers on
    output logic                           shutdown,    // powered down
    output logic                           dout_mode    // 1: rising
);
    // ------------------------------------------------------------
    // state and crossings
    // ------------------------------------------------------------
    core_state_t              q;
    core_state_t              d;
    logic [1:0]               pins_f;
    logic                     cs_f;
    logic                     hw_update_f_n;
    logic [`WORD_W-1:0]       link_word;
    logic [`CNT_W-1:0]        link_cnt;
    logic                     exec;
    logic [`CTRL_W-1:0]       ctrl;
    logic [`ADDR_W-1:0]       addr;
    logic [`DATA_W-1:0]       data;
    logic                     frame_end;

    // pins into the system domain
    in_sync3 #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_pins (
        .clock (clock),
        .rst   (rst),
        .din   ({cs_n, hw_update_n}),
        .dout  (pins_f)
    );

    assign cs_f          = pins_f[1];
    assign hw_update_f_n = pins_f[0];

    // link side shifter on the serial clock
    serial_link_shifter u_link (
        .sclk     (sclk),
        .rst      (rst),
        .cs_n     (cs_n),
        .sdi      (sdi),
        .mode_sel (q.mode),
        .sdo      (sdo),
        .word     (link_word),
        .bit_cnt  (link_cnt)
    );

    // ------------------------------------------------------------
    // decode of the captured word
    // ------------------------------------------------------------
    assign exec      = (q.st == ST_EXEC);
    assign ctrl      = ctrl_of(q.word);
    assign addr      = addr_of(q.word);
    assign data      = data_of(q.word);
    assign frame_end = cs_f && !q.cs_prev;

    // next state: capture at frame end, execute one cycle later
    always_comb begin
        d         = q;
        d.cs_prev = cs_f;
        d.st      = ST_IDLE;
        // word and count are still while deselected, so sample here
        if (frame_end) begin
            d.base_cnt = link_cnt;
            if (full_word(link_cnt, q.base_cnt)) begin
                d.word = link_word;
                d.st   = ST_EXEC;
            end
        end
        if (exec) begin
            unique case (ctrl)
                `CMD_PASS: begin
                    d.word = q.word;
                end
                `CMD_CLEAR: begin
                    d.inp      = '0;
                    d.dac      = '0;
                    d.shutdown = 1'b0;
                    d.buf_en   = `BUF_ALL_ON;
                end
                `CMD_SHDN: begin
                    d.shutdown = 1'b1;
                    d.buf_en   = data;
                end
                `CMD_PHASE: begin
                    d.mode = q.word[`MODE_BIT];
                    d.dac  = q.inp;
                end
                `CMD_ALL: begin
                    for (int i = 0; i < `NCH; i++) begin
                        d.dac[i] = data;
                    end
                    d.shutdown = 1'b0;
                    d.buf_en   = `BUF_ALL_ON;
                end
                `CMD_LD_IN: begin
                    d.inp[addr] = data;
                end
                `CMD_LD_BOTH: begin
                    d.inp[addr] = data;
                    d.dac[addr] = data;
                    d.shutdown  = 1'b0;
                    d.buf_en    = `BUF_ALL_ON;
                end
                `CMD_UPDATE: begin
                    d.dac = q.inp;
                end
            endcase
        end
        // update pin low: outputs follow input registers
        if (!hw_update_f_n) begin
            d.dac = d.inp;
        end
        if (rst) begin
            d.st       = ST_IDLE;
            d.word     = `WORD_ZERO;
            d.base_cnt = `CNT_ZERO;
            d.inp      = '0;
            d.dac      = '0;
            d.shutdown = 1'b0;
            d.buf_en   = `BUF_ALL_ON;
            d.mode     = 1'b0;
            d.cs_prev  = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // outputs, all from the state register
    // ------------------------------------------------------------
    assign dac_code  = q.dac;
    assign buf_en    = q.buf_en;
    assign shutdown  = q.shutdown;
    assign dout_mode = q.mode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pass_quiet : assert property (
        exec && ctrl == `CMD_PASS && hw_update_f_n
        |=> $stable(q.inp) && $stable(q.dac))
        else $error("pass-through changed a register");

    a_clear_zero : assert property (
        exec && ctrl == `CMD_CLEAR
        |=> q.inp == '0 && q.dac == '0)
        else $error("clear left a register nonzero");

    a_clear_wake : assert property (
        exec && ctrl == `CMD_CLEAR |=> !q.shutdown)
        else $error("clear did not end shutdown");

    a_shdn_bufs : assert property (
        exec && ctrl == `CMD_SHDN
        |=> q.shutdown && q.buf_en == $past(data))
        else $error("shutdown mask wrong");

    a_wake_cause : assert property (
        $fell(q.shutdown)
        |-> $past(exec && (ctrl == `CMD_CLEAR || ctrl == `CMD_ALL
                  || ctrl == `CMD_LD_BOTH)))
        else $error("shutdown ended without a waking command");

    a_phase_set : assert property (
        exec && ctrl == `CMD_PHASE
        |=> q.mode == $past(q.word[`MODE_BIT])
            && (!hw_update_f_n || q.dac == $past(q.inp)))
        else $error("phase command wrong");

    a_phase_hold : assert property (
        !(exec && ctrl == `CMD_PHASE) |=> $stable(q.mode))
        else $error("phase changed without command");

    a_load_all : assert property (
        exec && ctrl == `CMD_ALL && hw_update_f_n
        |=> q.dac == {`NCH{$past(data)}} && !q.shutdown)
        else $error("load-all wrong");

    a_load_input : assert property (
        exec && ctrl == `CMD_LD_IN && hw_update_f_n
        |=> q.inp[$past(addr)] == $past(data) && $stable(q.dac))
        else $error("load-input wrong");

    a_load_both : assert property (
        exec && ctrl == `CMD_LD_BOTH
        |=> q.inp[$past(addr)] == $past(data)
            && q.dac[$past(addr)] == $past(data) && !q.shutdown)
        else $error("load-both wrong");

    a_sw_update : assert property (
        exec && ctrl == `CMD_UPDATE |=> q.dac == $past(q.inp))
        else $error("software update wrong");

    a_transparent : assert property (
        !hw_update_f_n |=> q.dac == q.inp)
        else $error("outputs not following inputs");

    a_short_word : assert property (
        frame_end && !full_word(link_cnt, q.base_cnt)
        |=> q.st == ST_IDLE [*2])
        else $error("short word executed");

    a_exec_timing : assert property (
        frame_end && full_word(link_cnt, q.base_cnt)
        |=> exec ##1 !exec)
        else $error("execute slot wrong");

    a_reset_state : assert property (
        @(posedge clock) disable iff (1'b0)
        rst |=> q.dac == '0 && q.inp == '0 && !q.mode)
        else $error("reset state wrong");

    c_clear   : cover property (exec && ctrl == `CMD_CLEAR);
    c_shdn    : cover property (exec && ctrl == `CMD_SHDN ##[1:1000]
                                !q.shutdown);
    c_both    : cover property (exec && ctrl == `CMD_LD_BOTH);
    c_mode1   : cover property ($rose(q.mode));
    c_transp  : cover property (!hw_update_f_n && exec
                                && ctrl == `CMD_LD_IN);
endmodule : octal_dac_serial_command_decoder

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
    output logic      sclk, // link clock, idles low
    output logic      cs_n, // frame select
    output logic      sdi,  // data to device
    input  wire logic sdo   // chained data back
);
    logic [16:0] cap;       // sdo samples, oldest high

    // --------------------------------------------------------
    // link idle state
    // --------------------------------------------------------
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        sdi  = 1'h0;
        cap  = '0;
    end

    // a few link edges with the frame closed, for reset
    task automatic idle_pulses;
        repeat (3) begin
            #7.5 sclk = 1'h1;
            #7.5 sclk = 1'h0;
        end
    endtask : idle_pulses

    // one frame of n bits, msb first, one per rising edge;
    // deselected edges first let the reset and phase sync settle
    task automatic frame(input logic [47:0] bits, input int n);
        int k;
        idle_pulses();
        cs_n = 1'h0;
        #45;
        for (k = n - 1; k >= 0; k--) begin
            sdi = bits[k];
            #7.5 sclk = 1'h1;
            #5 if (k >= n - 17) cap = {cap[15:0], sdo};
            #2.5 sclk = 1'h0;
        end
        #2 if (n == 16) cap = {cap[15:0], sdo};
        sdi = ~sdi; // released line shows no stale value
        #40 cs_n = 1'h1;
    endtask : frame
endmodule : serial_host_model

/* File: tb/octal_dac_serial_command_decoder_tb_top.sv */
`timescale 1ns/1ps
`include "dac_cmd_params.svh"
module octal_dac_serial_command_decoder_tb_top;
    import dac_cmd_pkg::*;

    typedef struct packed {
        logic [`NCH*`DATA_W-1:0] code;
        logic [7:0]  bufs;
        logic        shd;
        logic        mode;
        logic        sdo_on;
        logic        sdo_md;
        logic [15:0] sdo_w;
    } note_t;

    logic        clock = 1'h0;
    logic        rst;
    logic        hw_update_n;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic        sdo;
    logic [`NCH*`DATA_W-1:0] dac_code;
    logic [7:0]  buf_en;
    logic        shutdown;
    logic        dout_mode;
    logic [7:0]  inp [`NCH];
    logic [7:0]  dac [`NCH];
    logic [7:0]  m_buf;
    logic        m_shd;
    logic        m_mode;
    logic [15:0] last_w;
    logic        last_ok;
    logic [15:0] lfsr;
    logic        chk_now;
    note_t       notes[$];
    note_t       cur;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #50 clock = ~clock;

    octal_dac_serial_command_decoder DUT (
        .clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .hw_update_n(hw_update_n), .sdo(sdo), .dac_code(dac_code),
        .buf_en(buf_en), .shutdown(shutdown), .dout_mode(dout_mode));

    serial_host_model host (
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic test_end(input string name);
        $display("test %s done", name);
    endtask : test_end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [15:0] word(input logic [2:0] a,
                                         input logic [2:0] c,
                                         input logic [7:0] d);
        return {2'h2, a, c, d};
    endfunction : word

    // expected effect of one whole word
    task automatic apply(input logic [15:0] w);
        logic [2:0] a;
        logic [7:0] d;
        logic       wake;
        a = w[13:11];
        d = w[7:0];
        wake = 1'h0;
        case (w[10:8])
            `CMD_CLEAR: begin
                inp = '{default: `CODE_ZERO};
                dac = '{default: `CODE_ZERO};
                wake = 1'h1;
            end
            `CMD_SHDN: begin
                m_shd = 1'h1;
                m_buf = d;
            end
            `CMD_PHASE: begin
                m_mode = w[13];
                dac = inp;
            end
            `CMD_ALL: begin
                dac = '{default: d};
                wake = 1'h1;
            end
            `CMD_LD_IN: inp[a] = d;
            `CMD_LD_BOTH: begin
                inp[a] = d;
                dac[a] = d;
                wake = 1'h1;
            end
            `CMD_UPDATE: dac = inp;
            default: ;
        endcase
        if (wake) begin
            m_shd = 1'h0;
            m_buf = `BUF_ALL_ON;
        end
        if (!hw_update_n) dac = inp;
    endtask : apply

    // note the expected outputs, then flag the monitor
    task automatic post(input logic chk, input logic md);
        note_t nt;
        for (int i = 0; i < `NCH; i++) nt.code[8*i +: 8] = dac[i];
        nt.bufs = m_buf;
        nt.shd = m_shd;
        nt.mode = m_mode;
        nt.sdo_on = chk;
        nt.sdo_md = md;
        nt.sdo_w = last_w;
        notes.push_back(nt);
        repeat (8) @(negedge clock);
        chk_now = 1'h1;
        @(negedge clock);
        chk_now = 1'h0;
    endtask : post

    task automatic cmd(input logic [47:0] bits, input int n);
        logic md;
        logic ok;
        md = m_mode;
        ok = last_ok && (n >= 16);
        host.frame(bits, n);
        if (n >= 16) apply(bits[15:0]);
        post(ok, md);
        last_ok = (n >= 16);
        if (n >= 16) last_w = bits[15:0];
    endtask : cmd

    task automatic one(input logic [15:0] w);
        cmd({32'h0, w}, 16);
    endtask : one

    // --------------------------------------------------------
    // monitor: oldest note against the outputs
    // --------------------------------------------------------
    always @(posedge clock) begin
        if (chk_now === 1'h1 && notes.size() > 0) begin
            cur = notes.pop_front();
            check("dac_code", dac_code, cur.code);
            check("buf_en", 64'(buf_en), 64'(cur.bufs));
            check("shutdown", 64'(shutdown), 64'(cur.shd));
            check("dout_mode", 64'(dout_mode), 64'(cur.mode));
            if (cur.sdo_on) begin
                check("sdo", 64'(cur.sdo_md ? host.cap[16:1]
                      : host.cap[15:0]), 64'(cur.sdo_w));
                check("sdo_idle", 64'(sdo), 64'(host.cap[0]));
            end
        end
    end

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        int i;
        logic [2:0] ex [3];
        ex = '{`CMD_CLEAR, `CMD_ALL, `CMD_LD_BOTH};
        rst = 1'h1;
        hw_update_n = 1'h1;
        chk_now = 1'h0;
        lfsr = 16'h0013;
        m_buf = `BUF_ALL_ON;
        m_shd = 1'h0;
        m_mode = 1'h0;
        last_w = `WORD_ZERO;
        last_ok = 1'h1;
        inp = '{default: `CODE_ZERO};
        dac = '{default: `CODE_ZERO};
        repeat (2) @(negedge clock);
        host.idle_pulses();
        repeat (6) @(negedge clock);
        rst = 1'h0;
        repeat (3) @(negedge clock);
        check("sdo", 64'(sdo), 64'h0);
        post(1'h0, 1'h0);
        test_end("reset");
        for (i = 0; i < `NCH; i++) begin
            lfsr = lfsr_next(lfsr);
            one(word(3'(i), `CMD_LD_IN, lfsr[7:0]));
        end
        one(word(3'h2, `CMD_UPDATE, 8'h5A));
        one(word(3'h4, `CMD_LD_BOTH, 8'hC3));
        test_end("load");
        // shutdown survives the others, left by the wake commands
        for (i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            one(word(3'h5, `CMD_SHDN, lfsr[7:0]));
            one(word(3'h1, `CMD_LD_IN, lfsr[15:8]));
            one(word(3'h7, `CMD_UPDATE, 8'h00));
            one(word(3'h6, ex[i], lfsr[15:8]));
        end
        one(word(3'h3, `CMD_ALL, 8'h00));
        test_end("shutdown");
        // phase stays latched across other commands
        one(word(3'h4, `CMD_PHASE, 8'h96));
        one(word(3'h4, `CMD_PASS, 8'h69));
        one(word(3'h0, `CMD_SHDN, 8'h0F));
        one(word(3'h3, `CMD_PHASE, 8'h33));
        one(word(3'h7, `CMD_PASS, 8'hE1));
        test_end("phase");
        hw_update_n = 1'h0;
        dac = inp;
        repeat (4) @(negedge clock);
        one(word(3'h2, `CMD_LD_IN, 8'h7E));
        hw_update_n = 1'h1;
        repeat (4) @(negedge clock);
        one(word(3'h1, `CMD_LD_IN, 8'h81));
        test_end("hw_update");
        // short frame dropped; chained frame, farthest word first
        cmd({32'h0, word(3'h0, `CMD_CLEAR, 8'h00)}, 10);
        cmd({word(3'h1, `CMD_LD_BOTH, 8'h11), word(3'h0, `CMD_PASS, 8'h00),
             word(3'h5, `CMD_LD_BOTH, 8'h55)}, 48);
        one(word(3'h7, `CMD_PASS, 8'hAA));
        test_end("framing");
        close_out();
    end
endmodule : octal_dac_serial_command_decoder_tb_top
